/* rtl/pri_pkg.sv */
// Shared constants, types and register map of the modulator register interface.
package pri_pkg;

  // ************************************************************
  // Channel count and widths
  // ************************************************************
  localparam int NUM_CH = 8;
  localparam int CH_W = 3;
  localparam logic [7:0] NUM_CH_B = 8'h08;
  localparam int DUTY_W = 8;
  localparam int NUM_FIELDS = 4;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SHARED = 8'h04;
  localparam logic [7:0] OFS_MDUTY = 8'h08;
  localparam logic [7:0] OFS_MPICK = 8'h0c;
  localparam logic [7:0] OFS_IEN_SET = 8'h10;
  localparam logic [7:0] OFS_IEN_REM = 8'h14;
  localparam logic [7:0] OFS_IEN_STATE = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1c;
  localparam logic [7:0] OFS_STAT_CLR = 8'h20;
  localparam logic [7:0] OFS_TOP = 8'h2c;
  localparam logic [7:0] OFS_CHSET = 8'h30;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_CLR_BIT = 1;
  localparam int CTRL_TOP_LSB = 8;
  localparam int CTRL_SPR_LSB = 16;
  localparam int FLAG_TIMEBASE_OVERFLOW_FLAG_BIT = 0;
  localparam int FLAG_READY_BIT = 2;
  localparam int FLAG_BUSY_BIT = 3;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_TIME_NS = 20;
  localparam int SYNC_CYCLES = (SYNC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SYNC = 2'b01,
    ST_WAIT = 2'b10
  } pri_upd_e;

  typedef struct packed {
    logic busy;
    logic ready;
    logic timebase_overflow_flag;
  } pri_flags_s;

endpackage : pri_pkg

/* rtl/pri_sync_delay.sv */
// Fixed-length pulse delay standing for the update synchronisation time.
`timescale 1ns/1ps
module pri_sync_delay
  import pri_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic start_i, // One-cycle start pulse
  output logic done_o // One-cycle done pulse
);

  logic [SYNC_CYCLES-1:0] sh_r;

  // Shift the start pulse through the stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r <= '0;
    end else begin
      sh_r <= {sh_r[SYNC_CYCLES-2:0], start_i};
    end
  end

  assign done_o = sh_r[SYNC_CYCLES-1];

endmodule : pri_sync_delay

/* rtl/pri_channel.sv */
// One modulator channel: duty register and compare output.
`timescale 1ns/1ps
module pri_channel
  import pri_pkg::*;
(
  input wire logic clk_i, // System clock
  input wire logic rst_i, // Synchronous reset, high
  input wire logic en_i, // Modulator running
  input wire logic load_i, // Take new duty this cycle
  input wire logic [DUTY_W-1:0] duty_i, // New duty value
  input wire logic [DUTY_W-1:0] cnt_i, // Timebase count
  output logic pwm_o // Waveform output
);

  logic [DUTY_W-1:0] duty_r;
  logic pwm_r;

  // Duty only changes on the apply pulse, which comes at the wrap while running
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      duty_r <= RST_BYTE;
    end else if (load_i) begin
      duty_r <= duty_i;
    end
  end

  // High below duty; zero duty therefore never goes high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm_r <= 1'b0;
    end else begin
      pwm_r <= en_i && (cnt_i < duty_r);
    end
  end

  assign pwm_o = pwm_r;

  a_zero_duty_low: assert property (@(posedge clk_i) disable iff (rst_i)
    (duty_r == RST_BYTE) |=> !pwm_o)
    else $error("channel with zero duty drove its output high");

endmodule : pri_channel

/* rtl/pri_top.sv */
// Register interface, timebase and synchronised duty update of the modulator.
`timescale 1ns/1ps
module pri_top
(
  input wire logic CLK_I, // System clock, 100 MHz
  input wire logic RST_I, // Synchronous reset, high
  input wire logic PSEL_I, // APB select
  input wire logic PENABLE_I, // APB enable
  input wire logic PWRITE_I, // APB direction, high is write
  input wire logic [7:0] PADDR_I, // APB byte address
  input wire logic [31:0] PWDATA_I, // APB write data
  output logic [31:0] PRDATA_O, // APB read data
  output logic PREADY_O, // APB ready
  output logic PSLVERR_O, // APB error on unmapped address
  output logic [pri_pkg::NUM_CH-1:0] PWM_O, // Channel waveforms
  output logic IRQ_O // Interrupt request, high
);
  import pri_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic wr_acc;
  logic wr_ctrl, wr_shared, wr_mduty, wr_mpick, wr_chset, wr_top;
  logic wr_ien_set, wr_ien_rem, wr_clr;
  logic trig_duty, trig_clr, trig;
  logic en_r;
  logic [7:0] top_r, spread_r, shared_r;
  logic [31:0] mduty_r;
  logic [NUM_CH-1:0] pick_mask, pend_mask_r;
  logic [NUM_CH-1:0][DUTY_W-1:0] pick_duty, pend_duty_r;
  logic [7:0] sel;
  logic pend_clr_r;
  pri_upd_e state_r, state_nxt;
  logic sync_done, apply, clr_apply, wrap;
  logic [7:0] cnt_r, spr_r, eff_top;
  logic [8:0] top_sum;
  pri_flags_s flags;
  logic ready_r, timebase_overflow_flag_r, busy_d1_r;
  logic mask_ready_r, mask_timebase_overflow_flag_r;
  logic irq_r;
  logic [31:0] rd_word, prdata_r;
  logic mapped;

  // ************************************************************
  // APB decode
  // ************************************************************
  // Zero wait states; read data is captured in the setup cycle
  assign PREADY_O = 1'b1;
  assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I;
  assign wr_ctrl = wr_acc && (PADDR_I == OFS_CTRL) && !flags.busy;
  assign wr_shared = wr_acc && (PADDR_I == OFS_SHARED) && !flags.busy;
  assign wr_mduty = wr_acc && (PADDR_I == OFS_MDUTY) && !flags.busy;
  assign wr_mpick = wr_acc && (PADDR_I == OFS_MPICK) && !flags.busy;
  assign wr_chset = wr_acc && (PADDR_I == OFS_CHSET) && !flags.busy;
  assign wr_top = wr_acc && (PADDR_I == OFS_TOP) && !flags.busy;
  // Interrupt plumbing stays writable so software can wait on ready
  assign wr_ien_set = wr_acc && (PADDR_I == OFS_IEN_SET);
  assign wr_ien_rem = wr_acc && (PADDR_I == OFS_IEN_REM);
  assign wr_clr = wr_acc && (PADDR_I == OFS_STAT_CLR);

  // ************************************************************
  // Control word and top value
  // ************************************************************
  // Top lives in one register so both locations always agree
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      en_r <= 1'b0;
      top_r <= RST_BYTE;
      spread_r <= RST_BYTE;
    end else if (wr_ctrl) begin
      en_r <= PWDATA_I[CTRL_EN_BIT];
      top_r <= PWDATA_I[CTRL_TOP_LSB+:8];
      spread_r <= PWDATA_I[CTRL_SPR_LSB+:8];
    end else if (wr_top) begin
      top_r <= PWDATA_I[7:0];
    end
  end

  // Duty staging registers, write-only from software
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      shared_r <= RST_BYTE;
      mduty_r <= RST_WORD;
    end else begin
      if (wr_shared) shared_r <= PWDATA_I[7:0];
      if (wr_mduty) mduty_r <= PWDATA_I;
    end
  end

  // ************************************************************
  // Update request capture
  // ************************************************************
  assign trig_duty = wr_chset || wr_mpick;
  assign trig_clr = wr_ctrl && PWDATA_I[CTRL_CLR_BIT];
  assign trig = trig_duty || trig_clr;

  // Work out which channels get which duty from the trigger write
  always_comb begin
    pick_mask = '0;
    pick_duty = '0;
    sel = 8'h00;
    if (wr_chset) begin
      for (int ch = 0; ch < NUM_CH; ch++) begin
        pick_mask[ch] = PWDATA_I[ch];
        pick_duty[ch] = shared_r;
      end
    end else if (wr_mpick) begin
      // Ascending order so the highest field wins a repeated channel
      for (int f = 0; f < NUM_FIELDS; f++) begin
        sel = PWDATA_I[8*f+:8];
        if (sel < NUM_CH_B) begin
          pick_mask[sel[CH_W-1:0]] = 1'b1;
          pick_duty[sel[CH_W-1:0]] = mduty_r[8*f+:8];
        end
      end
    end
  end

  // Hold the request until it is applied
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      pend_mask_r <= '0;
      pend_duty_r <= '0;
      pend_clr_r <= 1'b0;
    end else if (trig) begin
      pend_mask_r <= pick_mask;
      pend_duty_r <= pick_duty;
      pend_clr_r <= trig_clr;
    end else begin
      if (apply) pend_mask_r <= '0;
      if (clr_apply) pend_clr_r <= 1'b0;
    end
  end

  // ************************************************************
  // Synchronisation sequencer
  // ************************************************************
  pri_sync_delay u_sync (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .start_i(trig && (state_r == ST_IDLE)),
    .done_o(sync_done)
  );

  // A stopped counter never reaches top, so apply at once then
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: state_nxt = trig ? ST_SYNC : ST_IDLE;
      ST_SYNC: state_nxt = !sync_done ? ST_SYNC : ((en_r && (pend_mask_r != '0)) ? ST_WAIT : ST_IDLE);
      ST_WAIT: state_nxt = (wrap || !en_r) ? ST_IDLE : ST_WAIT;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign apply = ((state_r == ST_SYNC) && sync_done && !(en_r && (pend_mask_r != '0))) ||
                 ((state_r == ST_WAIT) && (wrap || !en_r));
  assign clr_apply = (state_r == ST_SYNC) && sync_done && pend_clr_r;
  assign flags = '{busy: (state_r != ST_IDLE), ready: ready_r, timebase_overflow_flag: timebase_overflow_flag_r};

  // ************************************************************
  // Timebase and spread counters
  // ************************************************************
  // Saturate the top; wrap at or above it so a lowered top never strands the count
  assign top_sum = {1'b0, top_r} + {1'b0, spr_r};
  assign eff_top = top_sum[8] ? 8'hff : top_sum[7:0];
  assign wrap = en_r && (cnt_r >= eff_top) && !clr_apply;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cnt_r <= RST_BYTE;
    end else if (clr_apply) begin
      cnt_r <= RST_BYTE;
    end else if (en_r) begin
      cnt_r <= wrap ? RST_BYTE : cnt_r + 8'h01;
    end
  end

  // Spread steps once a period across zero to the limit
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      spr_r <= RST_BYTE;
    end else if (clr_apply) begin
      spr_r <= RST_BYTE;
    end else if (wrap) begin
      spr_r <= (spr_r >= spread_r) ? RST_BYTE : spr_r + 8'h01;
    end
  end

  // ************************************************************
  // Channels
  // ************************************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    pri_channel u_ch (
      .clk_i(CLK_I),
      .rst_i(RST_I),
      .en_i(en_r),
      .load_i(apply && pend_mask_r[g]),
      .duty_i(pend_duty_r[g]),
      .cnt_i(cnt_r),
      .pwm_o(PWM_O[g])
    );
  end

  // ************************************************************
  // Status flags, mask and interrupt
  // ************************************************************
  // Set beats clear so an event in the clear cycle is kept
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      busy_d1_r <= 1'b0;
      ready_r <= 1'b0;
      timebase_overflow_flag_r <= 1'b0;
    end else begin
      busy_d1_r <= flags.busy;
      if (busy_d1_r && !flags.busy) ready_r <= 1'b1;
      else if (wr_clr && PWDATA_I[FLAG_READY_BIT]) ready_r <= 1'b0;
      if (wrap) timebase_overflow_flag_r <= 1'b1;
      else if (wr_clr && PWDATA_I[FLAG_TIMEBASE_OVERFLOW_FLAG_BIT]) timebase_overflow_flag_r <= 1'b0;
    end
  end

  // Mask is touched only through the set and remove registers
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      mask_ready_r <= 1'b0;
      mask_timebase_overflow_flag_r <= 1'b0;
    end else if (wr_ien_set) begin
      mask_ready_r <= mask_ready_r || PWDATA_I[FLAG_READY_BIT];
      mask_timebase_overflow_flag_r <= mask_timebase_overflow_flag_r || PWDATA_I[FLAG_TIMEBASE_OVERFLOW_FLAG_BIT];
    end else if (wr_ien_rem) begin
      mask_ready_r <= mask_ready_r && !PWDATA_I[FLAG_READY_BIT];
      mask_timebase_overflow_flag_r <= mask_timebase_overflow_flag_r && !PWDATA_I[FLAG_TIMEBASE_OVERFLOW_FLAG_BIT];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (flags.timebase_overflow_flag && mask_timebase_overflow_flag_r) || (flags.ready && mask_ready_r);
    end
  end

  assign IRQ_O = irq_r;

  // ************************************************************
  // Read path
  // ************************************************************
  // Write-only registers read zero; the clear bit is never stored
  always_comb begin
    rd_word = RST_WORD;
    mapped = 1'b1;
    unique case (PADDR_I)
      OFS_CTRL: begin
        rd_word[CTRL_EN_BIT] = en_r;
        rd_word[CTRL_TOP_LSB+:8] = top_r;
        rd_word[CTRL_SPR_LSB+:8] = spread_r;
      end
      OFS_TOP: begin
        rd_word[7:0] = top_r;
      end
      OFS_IEN_STATE: begin
        rd_word[FLAG_READY_BIT] = mask_ready_r;
        rd_word[FLAG_TIMEBASE_OVERFLOW_FLAG_BIT] = mask_timebase_overflow_flag_r;
      end
      OFS_STAT: begin
        rd_word[FLAG_BUSY_BIT] = flags.busy;
        rd_word[FLAG_READY_BIT] = flags.ready;
        rd_word[FLAG_TIMEBASE_OVERFLOW_FLAG_BIT] = flags.timebase_overflow_flag;
      end
      OFS_SHARED, OFS_MDUTY, OFS_MPICK, OFS_IEN_SET, OFS_IEN_REM, OFS_STAT_CLR, OFS_CHSET: begin
        rd_word = RST_WORD;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      prdata_r <= RST_WORD;
    end else if (PSEL_I && !PENABLE_I && !PWRITE_I) begin
      prdata_r <= rd_word;
    end
  end

  assign PRDATA_O = prdata_r;
  assign PSLVERR_O = PSEL_I && PENABLE_I && !mapped;

  // ************************************************************
  // Checks
  // ************************************************************
  a_pick_sets_busy: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_mpick && (state_r == ST_IDLE)) |=> flags.busy [*2])
    else $error("pick write did not hold busy through sync");
  a_busy_discards: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_acc && (PADDR_I == OFS_CTRL) && flags.busy) |=> $stable(en_r) && $stable(top_r))
    else $error("control write taken while busy");
  a_ready_on_fall: assert property (@(posedge CLK_I) disable iff (RST_I)
    $fell(flags.busy) |=> ready_r)
    else $error("ready not set after busy fell");
  a_timebase_overflow_flag_on_wrap: assert property (@(posedge CLK_I) disable iff (RST_I)
    wrap |=> timebase_overflow_flag_r)
    else $error("overflow flag missed a wrap");
  a_irq_follows: assert property (@(posedge CLK_I) disable iff (RST_I)
    (timebase_overflow_flag_r && mask_timebase_overflow_flag_r) |=> IRQ_O)
    else $error("masked-in overflow gave no request");
  a_ien_sets: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_ien_set && PWDATA_I[FLAG_READY_BIT]) |=> mask_ready_r)
    else $error("enable-set write did not set mask");
  a_iren_clears: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_ien_rem && PWDATA_I[FLAG_TIMEBASE_OVERFLOW_FLAG_BIT]) |=> !mask_timebase_overflow_flag_r)
    else $error("enable-remove write did not clear mask");
  a_clr_flag: assert property (@(posedge CLK_I) disable iff (RST_I)
    (wr_clr && PWDATA_I[FLAG_TIMEBASE_OVERFLOW_FLAG_BIT] && !wrap && !mask_ready_r) |=> !timebase_overflow_flag_r ##1 (!IRQ_O || timebase_overflow_flag_r))
    else $error("status clear left overflow set");
  a_cnt_in_range: assert property (@(posedge CLK_I) disable iff (RST_I)
    en_r && $stable(eff_top) |-> cnt_r <= eff_top)
    else $error("timebase above effective top");
  a_apply_at_top: assert property (@(posedge CLK_I) disable iff (RST_I)
    (apply && en_r && (state_r == ST_WAIT)) |-> wrap && (cnt_r == eff_top))
    else $error("duty applied away from the top");
  a_timebase_clear_clears: assert property (@(posedge CLK_I) disable iff (RST_I)
    (trig_clr && (state_r == ST_IDLE)) |-> ##[1:4] (cnt_r == RST_BYTE))
    else $error("timebase clear had no effect");
  a_stop_holds: assert property (@(posedge CLK_I) disable iff (RST_I)
    (!en_r && !clr_apply) |=> $stable(cnt_r))
    else $error("timebase moved while disabled");

endmodule : pri_top

/* tb/pri_top_tb.sv */
// Self-checking bench for the modulator register interface.
`timescale 1ns/1ps
module pri_top_tb
  import pri_pkg::*;
;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [NUM_CH-1:0] pwm;
  logic [DUTY_W-1:0] duty_exp [NUM_CH];
  int hi_cnt [NUM_CH];
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;

  pri_top u_dut (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .PWM_O(pwm), .IRQ_O(irq));

  // ************************************************************
  // Clock, hang guard, reporting
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is about a thousand cycles, so this only trips on a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic stop_test();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // ************************************************************
  // Bus cycles
  // ************************************************************
  // Request held unchanged until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Poll busy; the hang guard bounds the wait
  task automatic wait_idle();
    do rd(OFS_STAT); while (rdat[FLAG_BUSY_BIT] !== 1'b0);
  endtask : wait_idle

  // ************************************************************
  // Expectations
  // ************************************************************
  function automatic int exp_hi(input logic [7:0] d, input int per);
    return (int'(d) < per) ? int'(d) : per;
  endfunction : exp_hi

  // Later fields overwrite earlier ones, absent channels skipped
  function automatic void apply_multi(input logic [31:0] pick, input logic [31:0] dv);
    for (int f = 0; f < NUM_FIELDS; f++) begin
      if (pick[8*f +: 8] < NUM_CH_B) duty_exp[pick[8*f +: CH_W]] = dv[8*f +: 8];
    end
  endfunction : apply_multi

  // High cycles over one full period equal the duty, whatever the phase
  task automatic check_pwm(input int per);
    for (int c = 0; c < NUM_CH; c++) hi_cnt[c] = 0;
    repeat (per) begin
      @(posedge clk);
      for (int c = 0; c < NUM_CH; c++) hi_cnt[c] += int'(pwm[c]);
    end
    for (int c = 0; c < NUM_CH; c++) chk(32'(hi_cnt[c]), 32'(exp_hi(duty_exp[c], per)));
  endtask : check_pwm

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [7:0] d;
    logic [7:0] ch;
    logic [31:0] pick, dv, mask;
    logic [7:0] ofs [4];
    time t0;
    int s;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    s = $urandom(32'h9dc9);
    for (int c = 0; c < NUM_CH; c++) duty_exp[c] = RST_BYTE;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // Reset values of the readable registers
    ofs = '{OFS_CTRL, OFS_IEN_STATE, OFS_STAT, OFS_TOP};
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i]);
      chk(rdat, RST_WORD);
    end
    // Mask set and remove, zeros ignored
    wr(OFS_IEN_SET, 32'h5);
    wr(OFS_IEN_REM, 32'h1);
    wr(OFS_IEN_SET, 32'h0);
    rd(OFS_IEN_STATE);
    chk(rdat, 32'h4);
    wr(OFS_IEN_REM, 32'h4);
    rd(OFS_IEN_STATE);
    chk(rdat, 32'h0);
    // Top value shared by both places
    wr(OFS_CTRL, 32'h0000_0900);
    rd(OFS_TOP);
    chk(rdat, 32'h9);
    wr(OFS_TOP, 32'h0c);
    rd(OFS_CTRL);
    chk(rdat, 32'h0c00);
    // Shared duty to a random set, modulator stopped
    d = 8'($urandom_range(12, 1));
    mask = 32'($urandom_range(255, 1));
    wr(OFS_SHARED, {24'h0, d});
    wr(OFS_CHSET, mask);
    rd(OFS_STAT);
    chk(32'(rdat[FLAG_BUSY_BIT]), 32'h1);
    wait_idle();
    for (int c = 0; c < NUM_CH; c++) if (mask[c]) duty_exp[c] = d;
    rd(OFS_STAT);
    chk(rdat, 32'h4);
    wr(OFS_STAT_CLR, 32'h4);
    rd(OFS_STAT);
    chk(rdat, 32'h0);
    // Four fields: absent pick, repeated pick, zero duty
    ch = 8'($urandom_range(7, 0));
    pick = {8'($urandom_range(7, 0)), ch, 8'(8 + $urandom_range(247, 0)), ch};
    dv = {8'h00, 8'($urandom_range(12, 1)), 8'($urandom_range(255, 1)), 8'($urandom_range(12, 1))};
    wr(OFS_MDUTY, dv);
    wr(OFS_MPICK, pick);
    wait_idle();
    apply_multi(pick, dv);
    wr(OFS_CTRL, 32'h0c01);
    repeat (3) @(posedge clk);
    check_pwm(13);
    rd(OFS_STAT);
    chk(32'(rdat[FLAG_TIMEBASE_OVERFLOW_FLAG_BIT]), 32'h1);
    wr(OFS_IEN_SET, 32'h1);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(irq), 32'h1);
    // Counter cleared, then a write while busy must be lost
    wr(OFS_CTRL, 32'hff03);
    wait_idle();
    d = 8'($urandom_range(254, 1));
    wr(OFS_SHARED, {24'h0, d});
    wr(OFS_CHSET, 32'hff);
    wr(OFS_CTRL, 32'h0c01);
    rd(OFS_CTRL);
    chk(rdat, 32'hff01);
    repeat (150) @(posedge clk);
    rd(OFS_STAT);
    chk(32'(rdat[FLAG_BUSY_BIT]), 32'h1);
    wait_idle();
    for (int c = 0; c < NUM_CH; c++) duty_exp[c] = d;
    check_pwm(256);
    // Stop, then clear flags and the request
    wr(OFS_CTRL, 32'h0c00);
    wr(OFS_STAT_CLR, 32'h5);
    rd(OFS_STAT);
    chk(rdat, 32'h0);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    chk(32'(pwm), 32'h0);
    rd(OFS_STAT_CLR);
    chk(rdat, 32'h0);
    // Spread 2 over top 3 gives periods 4, 5 and 6 in turn
    wr(OFS_SHARED, 32'h1);
    wr(OFS_CHSET, 32'h1);
    wait_idle();
    wr(OFS_CTRL, 32'h0002_0301);
    repeat (20) @(posedge clk);
    @(posedge pwm[0]);
    t0 = $time;
    repeat (3) @(posedge pwm[0]);
    chk(32'(($time - t0) / 10), 32'd15);
    // Unmapped place
    rd(8'h40);
    chk(32'(rerr), 32'h1);
    chk(rdat, 32'h0);
    stop_test();
  end
endmodule : pri_top_tb
